// >>> include/lcc_map.vh
`ifndef LCC_MAP_VH
`define LCC_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define LCC_CELL_BASE 8'h00
`define LCC_CTRL_A 8'h40
`define LCC_CTRL_B 8'h44
`define LCC_STATUS 8'h48
`define LCC_QVAL 8'h4C
`define LCC_COMB 8'h50

// ----------------------------------------------------------------
// Cell configuration word fields
// ----------------------------------------------------------------
`define LCC_LUT_HI 15
`define LCC_FF_LO 16
`define LCC_OSEL_LO 18
`define LCC_FB 21
`define LCC_CHAIN 22
`define LCC_ARITH 23
`define LCC_DSEL 24
`define LCC_CKSEL 25
`define LCC_CLR_LO 26
`define LCC_INV 28
`define LCC_PACK 29
`define LCC_CELL_MASK 32'h3FFFFFFF

// ----------------------------------------------------------------
// Storage element kinds and clear selects
// ----------------------------------------------------------------
`define LCC_FF_D 2'h0
`define LCC_FF_T 2'h1
`define LCC_FF_JK 2'h2
`define LCC_FF_SR 2'h3
`define LCC_CLR_A 2'h1
`define LCC_CLR_B 2'h2

// ----------------------------------------------------------------
// Control source codes and limits
// ----------------------------------------------------------------
`define LCC_ROW_LINES 4'h6
`define LCC_SRC_OFF 4'hF
`define LCC_MAX_LOCAL 4'h4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LCC_CELL_RST 32'h00000000
`define LCC_CTRL_A_RST 32'hFFFFFFFF
`define LCC_CTRL_B_RST 4'h0

`endif

// >>> src/lcc_cluster.v
`timescale 1ns/100ps
`include "lcc_map.vh"
module lcc_cluster (
  // Clock, enable and reset
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Control sources
  input wire [5:0] row_clk_i,
  input wire [3:0] ctl_local_i,
  input wire chip_wide_reset_n_i,
  // Cell data path
  input wire [63:0] cell_data_i,
  input wire carry_in_i,
  input wire chain_in_i,
  output reg [47:0] cell_out_o,
  output reg carry_out_o,
  output reg chain_out_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_local;
    input [3:0] src;
    begin
      is_local = (src[3:2] == 2'b10);
    end
  endfunction

  function is_used;
    input [3:0] src;
    begin
      is_used = (src != `LCC_SRC_OFF);
    end
  endfunction

  // Local lines are dropped when too many controls ask for them
  function src_level;
    input [3:0] src;
    input [5:0] row;
    input [3:0] loc;
    input lock;
    begin
      if (src < `LCC_ROW_LINES) begin
        src_level = row[src[2:0]];
      end else if (is_local(src)) begin
        src_level = loc[src[1:0]] & ~lock;
      end else begin
        src_level = 1'b0;
      end
    end
  endfunction

  // Next visible state of one storage element
  function ff_next;
    input [1:0] kind;
    input din;
    input kin;
    input vis;
    begin
      case (kind)
        `LCC_FF_D: ff_next = din;
        `LCC_FF_T: ff_next = vis ^ din;
        `LCC_FF_JK: ff_next = (din & ~vis) | (~kin & vis);
        `LCC_FF_SR: ff_next = din | (~kin & vis);
        default: ff_next = vis;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [31:0] cell_cfg [0:15];
  reg [31:0] ctrl_a;
  reg [3:0] ctrl_b;
  reg [15:0] q_raw;
  reg lvl_a_q;
  reg lvl_b_q;

  // ----------------------------------------------------------------
  // Shared control decode
  // ----------------------------------------------------------------
  reg [3:0] local_cnt;
  reg local_lock;
  reg [3:0] src_b;
  reg fall_b;
  reg lvl_a;
  reg lvl_b;
  reg cluster_clock_a_tick;
  reg cluster_clock_b_tick;
  reg cluster_clock_a_gate;
  reg cluster_clock_b_gate;
  reg cluster_async_clear_a;
  reg cluster_async_clear_b;
  reg sync_clear;
  reg sync_load;
  reg sload_used;
  reg chip_clear;
  integer k;

  always @* begin
    local_cnt = 4'h0;
    for (k = 0; k < 8; k = k + 1) begin
      local_cnt = local_cnt + {3'h0, is_local(ctrl_a[4*k +: 4])};
    end
    local_lock = (local_cnt > `LCC_MAX_LOCAL);
    // Both edges of one line use up both cluster clocks
    src_b = ctrl_b[2] ? ctrl_a[3:0] : ctrl_a[7:4];
    fall_b = ctrl_b[2] ? ~ctrl_b[0] : ctrl_b[1];
    lvl_a = src_level(ctrl_a[3:0], row_clk_i, ctl_local_i, local_lock);
    lvl_b = src_level(src_b, row_clk_i, ctl_local_i, local_lock);
    cluster_clock_a_tick = is_used(ctrl_a[3:0]) & (ctrl_b[0] ? (lvl_a_q & ~lvl_a) : (~lvl_a_q & lvl_a));
    cluster_clock_b_tick = is_used(src_b) & (fall_b ? (lvl_b_q & ~lvl_b) : (~lvl_b_q & lvl_b));
    sload_used = is_used(ctrl_a[31:28]);
    // Gate a is lost to the load line, so it reads as always on
    if (sload_used || !is_used(ctrl_a[11:8])) begin
      cluster_clock_a_gate = 1'b1;
    end else begin
      cluster_clock_a_gate = src_level(ctrl_a[11:8], row_clk_i, ctl_local_i, local_lock);
    end
    if (!is_used(ctrl_a[15:12])) begin
      cluster_clock_b_gate = 1'b1;
    end else begin
      cluster_clock_b_gate = src_level(ctrl_a[15:12], row_clk_i, ctl_local_i, local_lock);
    end
    cluster_async_clear_a = src_level(ctrl_a[19:16], row_clk_i, ctl_local_i, local_lock);
    cluster_async_clear_b = src_level(ctrl_a[23:20], row_clk_i, ctl_local_i, local_lock);
    sync_clear = src_level(ctrl_a[27:24], row_clk_i, ctl_local_i, local_lock);
    sync_load = src_level(ctrl_a[31:28], row_clk_i, ctl_local_i, local_lock);
    chip_clear = ctrl_b[3] & ~chip_wide_reset_n_i;
  end

  // ----------------------------------------------------------------
  // Cell data path
  // ----------------------------------------------------------------
  reg [15:0] inv_vec;
  reg [15:0] pack_vec;
  reg [15:0] q_vis;
  reg [16:0] carry;
  reg [15:0] comb_val;
  reg [15:0] din_val;
  reg [15:0] chain_src;
  reg [15:0] next_q_raw;
  reg [47:0] next_cell_out;
  reg [31:0] c;
  reg [3:0] lut_idx;
  reg a_in;
  reg b_in;
  reg c_in;
  reg d_in;
  reg tick;
  reg gate;
  reg aclr;
  reg vis_next;
  integer i;

  always @* begin
    c = 32'h0;
    lut_idx = 4'h0;
    a_in = 1'b0;
    b_in = 1'b0;
    c_in = 1'b0;
    d_in = 1'b0;
    tick = 1'b0;
    gate = 1'b0;
    aclr = 1'b0;
    vis_next = 1'b0;
    inv_vec = 16'h0;
    pack_vec = 16'h0;
    comb_val = 16'h0;
    din_val = 16'h0;
    next_q_raw = q_raw;
    next_cell_out = 48'h0;
    for (i = 0; i < 16; i = i + 1) begin
      inv_vec[i] = cell_cfg[i][`LCC_INV];
      pack_vec[i] = cell_cfg[i][`LCC_PACK];
    end
    // Preset is a clear seen through inverters around the register
    q_vis = q_raw ^ inv_vec;
    chain_src = {q_vis[14:0], chain_in_i};
    carry = 17'h0;
    carry[0] = carry_in_i;
    for (i = 0; i < 16; i = i + 1) begin
      c = cell_cfg[i];
      a_in = c[`LCC_FB] ? q_vis[i] : cell_data_i[4*i];
      b_in = cell_data_i[4*i+1];
      c_in = cell_data_i[4*i+2];
      d_in = cell_data_i[4*i+3];
      if (c[`LCC_ARITH]) begin
        comb_val[i] = a_in ^ b_in ^ carry[i];
        carry[i+1] = (a_in & b_in) | (carry[i] & (a_in ^ b_in));
      end else begin
        lut_idx = {(c[`LCC_DSEL] ? carry[i] : d_in), c_in, b_in, a_in};
        comb_val[i] = c[lut_idx];
        carry[i+1] = carry[i];
      end
      // Chained registers take the previous register, not the lookup
      din_val[i] = c[`LCC_CHAIN] ? chain_src[i] : comb_val[i];
      tick = c[`LCC_CKSEL] ? cluster_clock_b_tick : cluster_clock_a_tick;
      gate = c[`LCC_CKSEL] ? cluster_clock_b_gate : cluster_clock_a_gate;
      case (c[`LCC_CLR_LO+1:`LCC_CLR_LO])
        `LCC_CLR_A: aclr = cluster_async_clear_a;
        `LCC_CLR_B: aclr = cluster_async_clear_b;
        default: aclr = 1'b0;
      endcase
      vis_next = ff_next(c[`LCC_FF_LO+1:`LCC_FF_LO], din_val[i], c_in, q_vis[i]);
      if (chip_clear) begin
        next_q_raw[i] = 1'b0;
      end else if (aclr) begin
        next_q_raw[i] = 1'b0;
      end else if (tick) begin
        if (sync_clear) begin
          next_q_raw[i] = 1'b0;
        end else if (sync_load && !c[`LCC_PACK]) begin
          next_q_raw[i] = d_in ^ c[`LCC_INV];
        end else if (gate) begin
          next_q_raw[i] = vis_next ^ c[`LCC_INV];
        end
      end
      next_cell_out[3*i] = c[`LCC_OSEL_LO] ? q_vis[i] : comb_val[i];
      next_cell_out[3*i+1] = c[`LCC_OSEL_LO+1] ? q_vis[i] : comb_val[i];
      next_cell_out[3*i+2] = c[`LCC_OSEL_LO+2] ? q_vis[i] : comb_val[i];
    end
  end

  // ----------------------------------------------------------------
  // Cell registers and output flops
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_raw <= 16'h0;
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
      cell_out_o <= 48'h0;
      carry_out_o <= 1'b0;
      chain_out_o <= 1'b0;
    end else if (ce_i) begin
      q_raw <= next_q_raw;
      lvl_a_q <= lvl_a;
      lvl_b_q <= lvl_b;
      cell_out_o <= next_cell_out;
      carry_out_o <= carry[16];
      chain_out_o <= q_vis[15];
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  reg [31:0] rd_val;
  reg hit;
  reg ro;
  reg [2:0] status;
  integer j;

  always @* begin
    status = {sload_used & is_used(ctrl_a[11:8]), sload_used & (|pack_vec), local_lock};
    hit = (paddr_i[1:0] == 2'b00) && (paddr_i <= `LCC_COMB);
    ro = (paddr_i >= `LCC_STATUS);
    rd_val = 32'h0;
    if (paddr_i < `LCC_CTRL_A) begin
      rd_val = cell_cfg[paddr_i[5:2]];
    end else begin
      case (paddr_i)
        `LCC_CTRL_A: rd_val = ctrl_a;
        `LCC_CTRL_B: rd_val = {28'h0, ctrl_b};
        `LCC_STATUS: rd_val = {29'h0, status};
        `LCC_QVAL: rd_val = {15'h0, carry[16], q_vis};
        `LCC_COMB: rd_val = {16'h0, comb_val};
        default: rd_val = 32'h0;
      endcase
    end
  end

  // Write lands on the edge that samples pready high
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (j = 0; j < 16; j = j + 1) begin
        cell_cfg[j] <= `LCC_CELL_RST;
      end
      ctrl_a <= `LCC_CTRL_A_RST;
      ctrl_b <= `LCC_CTRL_B_RST;
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      if (psel_i && penable_i && !pready_o) begin
        pready_o <= 1'b1;
        prdata_o <= (hit && !pwrite_i) ? rd_val : 32'h0;
        pslverr_o <= !hit || (pwrite_i && ro);
      end else if (pready_o) begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
        if (psel_i && penable_i && pwrite_i && hit && !ro) begin
          if (paddr_i < `LCC_CTRL_A) begin
            cell_cfg[paddr_i[5:2]] <= pwdata_i & `LCC_CELL_MASK;
          end else if (paddr_i == `LCC_CTRL_A) begin
            ctrl_a <= pwdata_i;
          end else begin
            ctrl_b <= pwdata_i[3:0];
          end
        end
      end
    end
  end

endmodule // lcc_cluster

// >>> verif/lcc_cluster_assertions.sv
`timescale 1ns/100ps
module lcc_cluster_chk (
  // Clock, enable and reset
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Cell outputs
  input wire [47:0] cell_out_o,
  input wire carry_out_o,
  input wire chain_out_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence acc_s;
    psel_i && penable_i && !pready_o && ce_i;
  endsequence
  ready_answer_a: assert property (acc_s |=> pready_o) else $error("access not answered");
  ready_pulse_a: assert property (pready_o && ce_i |=> !pready_o) else $error("ready held over");
  ready_cause_a: assert property (!(psel_i && penable_i) |=> !pready_o) else $error("ready without access");
  err_pair_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  bad_addr_a: assert property (acc_s ##0 (paddr_i[1:0] != 2'h0 || paddr_i > 8'h50) |=> pslverr_o)
    else $error("bad address accepted");
  bad_read_a: assert property (acc_s ##0 (!pwrite_i && paddr_i > 8'h50) |=> prdata_o == 32'h0)
    else $error("bad read data not zero");
  ro_write_a: assert property (acc_s ##0 (pwrite_i && paddr_i >= 8'h48) |=> pslverr_o)
    else $error("read-only write accepted");
  good_addr_a: assert property (acc_s ##0 (paddr_i[1:0] == 2'h0 && paddr_i <= 8'h44) |=> !pslverr_o)
    else $error("good access refused");
  freeze_hold_a: assert property (rst_n_i && !ce_i |=> $stable(cell_out_o) && $stable(chain_out_o) && $stable(pready_o))
    else $error("state moved while frozen");
  reset_zero_a: assert property (disable iff (1'b0) !rst_n_i |=> cell_out_o == 48'h0 && !pready_o && !carry_out_o)
    else $error("outputs not cleared by reset");
endmodule // lcc_cluster_chk

bind lcc_cluster lcc_cluster_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .cell_out_o(cell_out_o), .carry_out_o(carry_out_o), .chain_out_o(chain_out_o));

// >>> verif/lcc_fabric.sv
`timescale 1ns/100ps
module lcc_fabric (
  // Clock
  input wire clk_i,
  // Lines into the cluster
  output reg [5:0] row_clk_o,
  output reg [3:0] ctl_local_o,
  output reg [63:0] data_o,
  output reg carry_o,
  output reg chain_o
);
  initial begin
    row_clk_o = 6'h00;
    ctl_local_o = 4'h0;
    data_o = 64'h0;
    carry_o = 1'b0;
    chain_o = 1'b0;
  end
  // Row line held two cycles each way so the sampled edge is seen once
  task tick(input int n);
    row_clk_o[n] <= 1'b1;
    repeat (2) @(posedge clk_i);
    row_clk_o[n] <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule // lcc_fabric

// >>> verif/test_logic_cell_cluster.sv
`timescale 1ns/100ps
module test_logic_cell_cluster;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg ce_i = 1'b1;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [7:0] paddr_i = 8'h00;
  reg [31:0] pwdata_i = 32'h0;
  reg chip_wide_reset_n_i = 1'b1;
  wire [31:0] prdata_o;
  wire pready_o;
  wire pslverr_o;
  wire [5:0] row_clk;
  wire [3:0] ctl_local;
  wire [63:0] cell_data;
  wire carry_in;
  wire chain_in;
  wire [47:0] cell_out_o;
  wire carry_out_o;
  wire chain_out_o;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  always #5 clk_i = ~clk_i;
  lcc_fabric i_fab (.clk_i(clk_i), .row_clk_o(row_clk), .ctl_local_o(ctl_local), .data_o(cell_data),
    .carry_o(carry_in), .chain_o(chain_in));
  lcc_cluster i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .row_clk_i(row_clk), .ctl_local_i(ctl_local), .chip_wide_reset_n_i(chip_wide_reset_n_i),
    .cell_data_i(cell_data), .carry_in_i(carry_in), .chain_in_i(chain_in), .cell_out_o(cell_out_o),
    .carry_out_o(carry_out_o), .chain_out_o(chain_out_o));
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Setup, access, wait for ready, then one idle edge before the next setup
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, 8'h40, 32'h0);
    chk("ctrl_a", 48'hFFFFFFFF, rd);
    apb(1'b0, 8'h44, 32'h0);
    chk("ctrl_b", 48'h0, rd);
    apb(1'b0, 8'h54, 32'h0);
    chk("unmapped", 48'h1, err);
    apb(1'b1, 8'h48, 32'h7);
    chk("ro_write", 48'h1, err);
    apb(1'b0, 8'h48, 32'h0);
    chk("status", 48'h0, rd);
    apb(1'b1, 8'h00, 32'h00006996);
    for (int v = 0; v < 16; v++) begin
      i_fab.data_o[3:0] <= v[3:0];
      repeat (2) @(posedge clk_i);
      chk("lookup", {45'h0, {3{^v[3:0]}}}, cell_out_o);
    end
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    apb(1'b1, 8'h40, 32'hF9FAF8F0);
    apb(1'b1, 8'h00, 32'h0418FF00);
    i_fab.ctl_local_o <= 4'h1;
    i_fab.data_o[3:0] <= 4'h8;
    i_fab.tick(0);
    apb(1'b0, 8'h4C, 32'h0);
    chk("q_set", 48'h1, rd[0]);
    i_fab.data_o[3:0] <= 4'h0;
    repeat (2) @(posedge clk_i);
    chk("packed", 48'h6, cell_out_o[2:0]);
    i_fab.ctl_local_o <= 4'h0;
    i_fab.tick(0);
    apb(1'b0, 8'h4C, 32'h0);
    chk("gated", 48'h1, rd[0]);
    i_fab.data_o[3:0] <= 4'h8;
    i_fab.ctl_local_o <= 4'h3;
    i_fab.tick(0);
    apb(1'b0, 8'h4C, 32'h0);
    chk("sync_clear", 48'h0, rd[0]);
    i_fab.ctl_local_o <= 4'h1;
    i_fab.tick(0);
    i_fab.ctl_local_o <= 4'h5;
    apb(1'b0, 8'h4C, 32'h0);
    chk("async_clear", 48'h0, rd[0]);
    i_fab.ctl_local_o <= 4'h1;
    i_fab.tick(0);
    apb(1'b1, 8'h44, 32'h8);
    chip_wide_reset_n_i <= 1'b0;
    apb(1'b0, 8'h4C, 32'h0);
    chk("chip_reset", 48'h0, rd[0]);
    chip_wide_reset_n_i <= 1'b1;
    apb(1'b1, 8'h00, 32'h00800000);
    i_fab.data_o[3:0] <= 4'h3;
    i_fab.carry_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("sum_c1", 48'h7, cell_out_o[2:0]);
    chk("carry_c1", 48'h1, carry_out_o);
    i_fab.carry_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("sum_c0", 48'h0, cell_out_o[2:0]);
    chk("carry_c0", 48'h1, carry_out_o);
    for (int j = 0; j < 16; j++) begin
      apb(1'b1, {j[5:0], 2'b00}, 32'h00400000);
    end
    i_fab.chain_o <= 1'b1;
    repeat (15) i_fab.tick(0);
    chk("chain_15", 48'h0, chain_out_o);
    i_fab.tick(0);
    chk("chain_16", 48'h1, chain_out_o);
    apb(1'b0, 8'h4C, 32'h0);
    chk("chain_q", 48'hFFFF, rd[15:0]);
    i_fab.chain_o <= 1'b0;
    apb(1'b1, 8'h00, 32'h2418FF00);
    apb(1'b1, 8'h40, 32'h89ABF8F0);
    apb(1'b0, 8'h48, 32'h0);
    chk("conflicts", 48'h7, rd[2:0]);
    print_verdict();
  end
endmodule // test_logic_cell_cluster
